// >>> rtl/pcx_port_cell.sv
// pcx_port_cell.sv: port cell control, pad read-back and pin crossbar
// assumes pads resolved outside from out/oe/pull, pad_in synchronous-ish
// to clock only through the two-stage sampler inside
`timescale 1ns/1ns
`include "pcx_params.svh"
module pcx_port_cell
  import pcx_pkg::*;
(
  // clock and reset
  input logic clock,
  input logic rst_b,
  // axi4-lite register bus
  input pcx_axi_req_t axi_req,
  output pcx_axi_rsp_t axi_rsp,
  // pads
  input pcx_pins_t pad_in,
  output pcx_pad_t pad,
  // crossbar peripherals
  input pcx_per_in_t per_in,
  output pcx_per_out_t per_out
);

  //****************************************
  // reset release
  //****************************************

  // two-flop release so the rest of the block leaves reset cleanly
  logic [1:0] rst_pipe;
  logic rst_n;

  // async assert, clocked release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  //****************************************
  // helpers
  //****************************************

  // lowest pin not yet taken; top bit says one was found
  function automatic logic [5:0] find_free(input pcx_pins_t taken);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `PCX_NPINS - 1; i >= 0; i--) begin
      if (!taken[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // merge write data into an old word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  //****************************************
  // state
  //****************************************

  // reset image: pads float with pull-ups on, all pins digital
  localparam pcx_state_t RST_STATE = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    pad: '{pull: '1, rx_en: '1, default: '0},
    per: '{default: '1},
    latch: `PCX_LATCH_RST,
    in_mode: `PCX_INMODE_RST,
    out_mode: `PCX_OUTMODE_RST,
    drive: `PCX_DRIVE_RST,
    skip: `PCX_SKIP_RST,
    default: '0
  };

  pcx_state_t st; // registered state
  pcx_state_t next_st; // next value

  //****************************************
  // next-state logic
  //****************************************

  // bus slave, crossbar decode and pad cells in one pass
  always_comb begin
    pcx_pins_t taken;
    logic [5:0] f;
    logic [31:0] tmp;
    logic val;
    logic od;
    logic dig;
    logic drv;
    taken = '0;
    f = 6'h00;
    tmp = 32'h0;
    val = 1'b0;
    od = 1'b0;
    dig = 1'b0;
    drv = 1'b0;
    next_st = st;

    // write address and data are taken in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.have_aw = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.have_w = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    // response retires when the master takes it
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end

    // both halves held: perform the write
    if (st.have_aw && st.have_w && !st.rsp.bvalid) begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = `PCX_RESP_OKAY;
      if (st.awaddr == `PCX_OFS_LATCH) begin
        tmp = merge(32'(st.latch), st.wdata, st.wstrb);
        next_st.latch = tmp[`PCX_NPINS-1:0];
      end else if (st.awaddr == `PCX_OFS_INMODE) begin
        tmp = merge(32'(st.in_mode), st.wdata, st.wstrb);
        next_st.in_mode = tmp[`PCX_NPINS-1:0];
      end else if (st.awaddr == `PCX_OFS_OUTMODE) begin
        tmp = merge(32'(st.out_mode), st.wdata, st.wstrb);
        next_st.out_mode = tmp[`PCX_NPINS-1:0];
      end else if (st.awaddr == `PCX_OFS_DRIVE) begin
        // strength bits go straight to the pads
        tmp = merge(32'(st.drive), st.wdata, st.wstrb); // see [R11]
        next_st.drive = tmp[`PCX_NPINS-1:0];
      end else if (st.awaddr == `PCX_OFS_SKIP) begin
        tmp = merge(32'(st.skip), st.wdata, st.wstrb);
        next_st.skip = tmp[`PCX_NPINS-1:0];
      end else if (st.awaddr == `PCX_OFS_ROUTE) begin
        tmp = merge({28'h0, st.xbar_en, st.wpd, st.smb_en, st.uart_en},
          st.wdata, st.wstrb);
        next_st.uart_en = tmp[`PCX_ROUTE_UART];
        next_st.smb_en = tmp[`PCX_ROUTE_SMB];
        next_st.wpd = tmp[`PCX_ROUTE_WPD];
        next_st.xbar_en = tmp[`PCX_ROUTE_XBAR];
      end else if (st.awaddr == `PCX_OFS_PADREAD ||
        st.awaddr == `PCX_OFS_ASSIGN) begin
        // read-only words: write ignored, still okay
        next_st.rsp.bresp = `PCX_RESP_OKAY;
      end else begin
        // unmapped or misaligned
        next_st.rsp.bresp = `PCX_RESP_SLVERR;
      end
    end

    // read channel: one read at a time, answer next cycle
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp = `PCX_RESP_OKAY;
      next_st.rsp.rdata = 32'h0;
      if (axi_req.araddr == `PCX_OFS_LATCH) begin
        next_st.rsp.rdata = 32'(st.latch);
      end else if (axi_req.araddr == `PCX_OFS_INMODE) begin
        next_st.rsp.rdata = 32'(st.in_mode);
      end else if (axi_req.araddr == `PCX_OFS_OUTMODE) begin
        next_st.rsp.rdata = 32'(st.out_mode);
      end else if (axi_req.araddr == `PCX_OFS_DRIVE) begin
        next_st.rsp.rdata = 32'(st.drive);
      end else if (axi_req.araddr == `PCX_OFS_SKIP) begin
        next_st.rsp.rdata = 32'(st.skip);
      end else if (axi_req.araddr == `PCX_OFS_ROUTE) begin
        next_st.rsp.rdata = {28'h0, st.xbar_en, st.wpd, st.smb_en,
          st.uart_en};
      end else if (axi_req.araddr == `PCX_OFS_PADREAD) begin
        // pad level, whoever owns the pin
        next_st.rsp.rdata = 32'(st.pad_read); // see [R12]
      end else if (axi_req.araddr == `PCX_OFS_ASSIGN) begin
        next_st.rsp.rdata = 32'(st.assigned);
      end else begin
        next_st.rsp.rresp = `PCX_RESP_SLVERR;
      end
    end

    // readies only while nothing is pending
    next_st.rsp.awready = !next_st.have_aw && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.have_w && !next_st.rsp.bvalid;
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // crossbar: skipped and ineligible pins count as taken
    taken = st.skip | ~pcx_pins_t'(`PCX_ELIGIBLE); // see [R13] [R14]
    // crystal pins are only protected by their skip bits
    // software must set them when the oscillator runs; see [R17]
    next_st.uart_ok = st.xbar_en && st.uart_en &&
      !taken[`PCX_UART_TX_PIN] && !taken[`PCX_UART_RX_PIN];
    if (next_st.uart_ok) begin
      // fixed placement, never moved by lower free pins
      taken[`PCX_UART_TX_PIN] = 1'b1; // see [R15]
      taken[`PCX_UART_RX_PIN] = 1'b1;
    end
    // two-wire bus: data then clock on the lowest free pins
    f = find_free(taken); // see [R18]
    next_st.sda_idx = f[4:0];
    next_st.smb_ok = st.xbar_en && st.smb_en && f[5];
    if (next_st.smb_ok) begin
      taken[f[4:0]] = 1'b1;
    end
    f = find_free(taken);
    next_st.scl_idx = f[4:0];
    next_st.smb_ok = next_st.smb_ok && f[5];
    next_st.assigned = '0;
    if (next_st.uart_ok) begin
      next_st.assigned[`PCX_UART_TX_PIN] = 1'b1;
      next_st.assigned[`PCX_UART_RX_PIN] = 1'b1;
    end
    if (next_st.smb_ok) begin
      next_st.assigned[next_st.sda_idx] = 1'b1;
      next_st.assigned[next_st.scl_idx] = 1'b1;
    end

    // pad cells, one per pin
    for (int i = 0; i < `PCX_NPINS; i++) begin
      val = st.latch[i];
      od = !st.out_mode[i]; // see [R7] [R8]
      if (next_st.uart_ok && i == `PCX_UART_TX_PIN) begin
        val = per_in.uart_tx;
      end
      if (next_st.smb_ok && 5'(i) == next_st.sda_idx) begin
        val = per_in.sda_drv;
        od = 1'b1; // see [R19]
      end
      if (next_st.smb_ok && 5'(i) == next_st.scl_idx) begin
        val = per_in.scl_drv;
        od = 1'b1; // see [R19]
      end
      dig = st.in_mode[i]; // see [R3]
      // analog or crossbar off: both drivers off
      drv = dig && st.xbar_en && (od ? !val : 1'b1); // see [R2] [R4]
      next_st.pad.oe[i] = drv;
      // open-drain never drives high
      next_st.pad.out[i] = od ? 1'b0 : val; // see [R8]
      // pull-up only while not sinking; global kill wins
      next_st.pad.pull[i] = dig && !st.wpd &&
        !(drv && !next_st.pad.out[i]); // see [R9] [R10] [R4]
      next_st.pad.rx_en[i] = dig; // see [R4]
      next_st.pad.drive_hi[i] = st.drive[i]; // see [R11]
    end

    // two-stage sampler; first stage feeds only the second
    next_st.sync1 = pad_in; // see [R20]
    next_st.sync2 = st.sync1;
    // analog pins read zero, digital pins read the pad
    next_st.pad_read = st.sync2 & st.in_mode; // see [R5] [R6]

    // peripheral inputs idle high when unrouted
    next_st.per.uart_rx = st.uart_ok ?
      st.sync2[`PCX_UART_RX_PIN] : 1'b1;
    next_st.per.sda_in = st.smb_ok ? st.sync2[st.sda_idx] : 1'b1;
    next_st.per.scl_in = st.smb_ok ? st.sync2[st.scl_idx] : 1'b1;
  end

  //****************************************
  // state register
  //****************************************

  // one register for the whole record; outputs come from it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= RST_STATE; // see [R1]
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp = st.rsp;
  assign pad = st.pad;
  assign per_out = st.per;

  //****************************************
  // assertions
  //****************************************

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // crossbar off means no pad is driven next cycle
  xbar_off_a: assert property (!st.xbar_en |=> st.pad.oe == '0) // see [R2]
    else $error("pad driven while crossbar disabled");

  // analog pins keep every digital part off
  analog_off_a: assert property (1'b1 |=> ( // see [R4]
    (st.pad.oe | st.pad.pull | st.pad.rx_en) & ~$past(st.in_mode)) == '0)
    else $error("analog pin has digital part on");

  // analog pins read back zero
  analog_read_a: assert property (1'b1 |=> // see [R5]
    (st.pad_read & ~$past(st.in_mode)) == '0)
    else $error("analog pin read nonzero");

  // digital pins read the sampled pad
  digital_read_a: assert property (1'b1 |=> // see [R6]
    (st.pad_read & $past(st.in_mode)) ==
    ($past(st.sync2) & $past(st.in_mode)))
    else $error("digital read differs from pad");

  // high side only on push-pull pins
  high_side_a: assert property (1'b1 |=> // see [R8]
    (st.pad.oe & st.pad.out & ~$past(st.out_mode)) == '0)
    else $error("open-drain pin driven high");

  // no pull-up while sinking
  pull_low_a: assert property ( // see [R9]
    (st.pad.pull & st.pad.oe & ~st.pad.out) == '0)
    else $error("pull-up on while driving low");

  // global disable clears all pull-ups
  pull_kill_a: assert property (st.wpd |=> st.pad.pull == '0) // see [R10]
    else $error("pull-up on under global disable");

  // skipped pins never show as assigned
  skip_never_a: assert property (1'b1 |=> // see [R13]
    (st.assigned & $past(st.skip)) == '0)
    else $error("skipped pin assigned");

  // serial port lands on pins 4 and 5
  uart_fixed_a: assert property (st.xbar_en && st.uart_en && // see [R15]
    !st.skip[`PCX_UART_TX_PIN] && !st.skip[`PCX_UART_RX_PIN] |=>
    st.uart_ok && st.assigned[`PCX_UART_RX_PIN:`PCX_UART_TX_PIN] == 2'h3)
    else $error("serial port not at fixed pins");

endmodule

// >>> rtl/pcx_params.svh
// pcx_params.svh: offsets, field positions, reset values, pin positions
// assumes inclusion by the port cell package and the port cell block
// Functional notes
// [R1] after reset pads float, pull-ups on
// [R2] crossbar disabled: all drivers off
// [R3] input mode bit: 0 analog, 1 digital
// [R4] analog pin: pull-up, driver, receiver off
// [R5] analog pin always reads zero
// [R6] digital pin reads pad, not latch
// [R7] push-pull drives pad high or low
// [R8] open-drain: low only, else floats
// [R9] pull-up on undriven, off driving low
// [R10] global disable bit kills all pull-ups
// [R11] per-pin drive strength, default low
// [R12] pad read ignores crossbar assignment
// [R13] skipped pin never claimed by crossbar
// [R14] only eligible unskipped pins get peripherals
// [R15] first serial port fixed at pins 4,5
// [R16] software skips gpio and bypass pins
// [R17] crystal pins fixed at pins 2,3
// [R18] peripheral gets lowest free unskipped pin
// [R19] two-wire bus pins always open-drain
// [R20] pad level synchronised in two stages
`ifndef PCX_PARAMS_SVH
`define PCX_PARAMS_SVH
`define PCX_NPINS 24
`define PCX_OFS_LATCH 5'h00
`define PCX_OFS_INMODE 5'h04
`define PCX_OFS_OUTMODE 5'h08
`define PCX_OFS_DRIVE 5'h0C
`define PCX_OFS_SKIP 5'h10
`define PCX_OFS_ROUTE 5'h14
`define PCX_OFS_PADREAD 5'h18
`define PCX_OFS_ASSIGN 5'h1C
`define PCX_ROUTE_UART 0
`define PCX_ROUTE_SMB 1
`define PCX_ROUTE_WPD 2
`define PCX_ROUTE_XBAR 3
`define PCX_LATCH_RST 24'hFFFFFF
`define PCX_INMODE_RST 24'hFFFFFF
`define PCX_OUTMODE_RST 24'h000000
`define PCX_DRIVE_RST 24'h000000
`define PCX_SKIP_RST 24'h000000
`define PCX_ELIGIBLE 24'hFFFFFF
`define PCX_UART_TX_PIN 4
`define PCX_UART_RX_PIN 5
`define PCX_XTAL_IN_PIN 2
`define PCX_XTAL_OUT_PIN 3
`define PCX_RESP_OKAY 2'h0
`define PCX_RESP_SLVERR 2'h2
`endif

// >>> rtl/pcx_pkg.sv
// pcx_pkg.sv: carrier structs and the state record of the port cell block
// assumes pcx_params.svh is on the include path
`include "pcx_params.svh"
package pcx_pkg;
  typedef logic [`PCX_NPINS-1:0] pcx_pins_t;
  // axi4-lite request side, master to slave
  typedef struct packed {
    logic awvalid; logic [4:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [4:0] araddr;
    logic rready;
  } pcx_axi_req_t;
  // axi4-lite answer side, slave to master
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid; logic [1:0] bresp;
    logic arready;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } pcx_axi_rsp_t;
  // per-pin pad controls
  typedef struct packed {
    pcx_pins_t out; pcx_pins_t oe; pcx_pins_t pull;
    pcx_pins_t drive_hi; pcx_pins_t rx_en;
  } pcx_pad_t;
  // peripheral levels into and out of the crossbar
  typedef struct packed {
    logic uart_tx; logic sda_drv; logic scl_drv;
  } pcx_per_in_t;
  typedef struct packed {
    logic uart_rx; logic sda_in; logic scl_in;
  } pcx_per_out_t;
  // whole state of the block
  typedef struct packed {
    pcx_axi_rsp_t rsp; pcx_pad_t pad; pcx_per_out_t per;
    logic have_aw; logic have_w; logic [4:0] awaddr;
    logic [31:0] wdata; logic [3:0] wstrb;
    pcx_pins_t latch; pcx_pins_t in_mode; pcx_pins_t out_mode;
    pcx_pins_t drive; pcx_pins_t skip;
    logic uart_en; logic smb_en; logic wpd; logic xbar_en;
    pcx_pins_t sync1; pcx_pins_t sync2; pcx_pins_t pad_read;
    pcx_pins_t assigned;
    logic uart_ok; logic smb_ok; logic [4:0] sda_idx; logic [4:0] scl_idx;
  } pcx_state_t;
endpackage

// >>> verif/pcx_pad_model.sv
// pcx_pad_model.sv: external circuits at the pads of the port cell block
// assumes the bench sets ext_drv and ext_val off the clock edge
`timescale 1ns/1ns
`include "pcx_params.svh"
module pcx_pad_model
  import pcx_pkg::*;
(
  // clock
  input logic clock,
  // cell controls and external drivers
  input pcx_pad_t pad,
  input pcx_pins_t ext_drv,
  input pcx_pins_t ext_val,
  // resolved pad levels
  output pcx_pins_t pad_in
);
  // ****************************************
  // floating pads
  // ****************************************
  // an unheld pad toggles every cycle, so a missing pull never reads stable
  pcx_pins_t float_pat = 24'h5A5A5A;
  always @(posedge clock) begin
    float_pat <= ~float_pat;
  end
  // ****************************************
  // wire resolution
  // ****************************************
  // cell driver first, then the outside circuit, then the weak pull-up
  always_comb begin
    for (int i = 0; i < `PCX_NPINS; i++) begin
      if (pad.oe[i]) begin
        pad_in[i] = pad.out[i];
      end else if (ext_drv[i]) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = pad.pull[i] ? 1'h1 : float_pat[i];
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
// tb_top.sv: self-checking bench for the port cell block over axi4-lite
// assumes pcx_pkg and pcx_pad_model are compiled before it
`timescale 1ns/1ns
`include "pcx_params.svh"
module tb_top
  import pcx_pkg::*;
  ;
  // ****************************************
  // signals
  // ****************************************
  logic clock;
  logic rst_b;
  pcx_axi_req_t req; // bus master side
  pcx_axi_rsp_t rsp; // slave answers
  pcx_pins_t pad_in; // resolved pads
  pcx_pins_t ext_drv; // outside circuit holds the pad
  pcx_pins_t ext_val; // level it holds
  pcx_pad_t pad;
  pcx_per_in_t per_in;
  pcx_per_out_t per_out;
  int errors;
  int total_checks;
  logic [31:0] rst_tab [6] = '{32'(`PCX_LATCH_RST), 32'(`PCX_INMODE_RST),
    32'(`PCX_OUTMODE_RST), 32'(`PCX_DRIVE_RST), 32'(`PCX_SKIP_RST), 32'h0};
  // ****************************************
  // instances
  // ****************************************
  pcx_port_cell pcx_port_cell_inst (.clock(clock), .rst_b(rst_b),
    .axi_req(req), .axi_rsp(rsp), .pad_in(pad_in), .pad(pad),
    .per_in(per_in), .per_out(per_out));
  pcx_pad_model pcx_pad_model_inst (.clock(clock), .pad(pad),
    .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));
  // free-running 100 mhz clock
  always #5 clock = ~clock;
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a hung handshake counts as a mismatch and ends the run
  task automatic hang();
    errors++;
    $display("[FAIL] %0t bus answer missing", $time);
    end_of_test();
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge clock);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clock);
      if (req.awvalid && rsp.awready) begin
        req.awvalid <= 1'h0;
      end
      if (req.wvalid && rsp.wready) begin
        req.wvalid <= 1'h0;
      end
      if (rsp.bvalid === 1'h1) begin
        chk(32'(rsp.bresp), 32'(er));
        req.bready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  // read: data and response taken at the edge that shows rvalid
  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge clock);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clock);
      if (req.arvalid && rsp.arready) begin
        req.arvalid <= 1'h0;
      end
      if (rsp.rvalid === 1'h1) begin
        chk(rsp.rdata, ed);
        chk(32'(rsp.rresp), 32'(er));
        req.rready <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  // config reaches pads in one edge, pad levels in three: five is ample
  task automatic settle();
    repeat (5) @(posedge clock);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clock = 1'h0;
    rst_b = 1'h0;
    req = '0;
    ext_drv = '0;
    ext_val = '0;
    per_in = '1;
    errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    repeat (3) @(posedge clock);
    // reset state of pads and registers
    chk(32'(pad.oe), 32'h0);
    chk(32'(pad.pull), 32'hFFFFFF);
    chk(32'(pad.drive_hi), 32'h0);
    for (int i = 0; i < 6; i++) begin
      rd(5'(i * 4), rst_tab[i], `PCX_RESP_OKAY);
    end
    rd(`PCX_OFS_PADREAD, 32'hFFFFFF, `PCX_RESP_OKAY);
    $display("test reset done");
    // bus refusals at unaligned places; write to read-only place still answered okay
    rd(5'h02, 32'h0, `PCX_RESP_SLVERR);
    wr(5'h06, 32'h0, `PCX_RESP_SLVERR);
    wr(`PCX_OFS_PADREAD, 32'h0, `PCX_RESP_OKAY);
    rd(`PCX_OFS_PADREAD, 32'hFFFFFF, `PCX_RESP_OKAY);
    $display("test bus done");
    // push-pull, crossbar off then on
    wr(`PCX_OFS_OUTMODE, 32'hFFFFFF, `PCX_RESP_OKAY);
    wr(`PCX_OFS_LATCH, 32'h0, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.oe), 32'h0);
    wr(`PCX_OFS_ROUTE, 32'h8, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.oe), 32'hFFFFFF);
    chk(32'(pad.pull), 32'h0);
    wr(`PCX_OFS_LATCH, 32'hA5A5A5, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.out), 32'hA5A5A5);
    rd(`PCX_OFS_PADREAD, 32'hA5A5A5, `PCX_RESP_OKAY);
    $display("test push_pull done");
    // open-drain with an outside circuit sinking pins 0 and 1
    ext_drv <= 24'h000003;
    wr(`PCX_OFS_OUTMODE, 32'h0, `PCX_RESP_OKAY);
    wr(`PCX_OFS_LATCH, 32'h0F0F0F, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.oe), 32'hF0F0F0);
    chk(32'(pad.out), 32'h0);
    chk(32'(pad.pull), 32'h0F0F0F);
    rd(`PCX_OFS_PADREAD, 32'h0F0F0C, `PCX_RESP_OKAY);
    rd(`PCX_OFS_LATCH, 32'h0F0F0F, `PCX_RESP_OKAY);
    wr(`PCX_OFS_ROUTE, 32'hC, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.pull), 32'h0);
    wr(`PCX_OFS_ROUTE, 32'h8, `PCX_RESP_OKAY);
    $display("test open_drain done");
    // low byte analog and skipped, outside drives it high
    ext_drv <= 24'h0000FF;
    ext_val <= 24'h0000FF;
    wr(`PCX_OFS_SKIP, 32'h0000FF, `PCX_RESP_OKAY);
    wr(`PCX_OFS_INMODE, 32'hFFFF00, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.rx_en), 32'hFFFF00);
    chk(32'(pad.oe), 32'hF0F000);
    chk(32'(pad.pull), 32'h0F0F00);
    rd(`PCX_OFS_PADREAD, 32'h0F0F00, `PCX_RESP_OKAY);
    $display("test analog done");
    // drive strength per pin
    wr(`PCX_OFS_DRIVE, 32'h123456, `PCX_RESP_OKAY);
    settle();
    chk(32'(pad.drive_hi), 32'h123456);
    rd(`PCX_OFS_DRIVE, 32'h123456, `PCX_RESP_OKAY);
    $display("test drive done");
    // crossbar with serial port and two-wire bus, pin 5 held low outside
    ext_drv <= 24'h000020;
    ext_val <= 24'h0;
    per_in <= 3'b001;
    wr(`PCX_OFS_INMODE, 32'hFFFFFF, `PCX_RESP_OKAY);
    wr(`PCX_OFS_SKIP, 32'h0, `PCX_RESP_OKAY);
    wr(`PCX_OFS_LATCH, 32'hFFFFFF, `PCX_RESP_OKAY);
    wr(`PCX_OFS_ROUTE, 32'hB, `PCX_RESP_OKAY);
    settle();
    chk(32'(per_out.uart_rx), 32'h0);
    chk(32'(pad.oe[4:0]), 32'h11);
    chk(32'({per_out.sda_in, per_out.scl_in}), 32'h1);
    rd(`PCX_OFS_ASSIGN, 32'h000033, `PCX_RESP_OKAY);
    rd(`PCX_OFS_PADREAD, 32'hFFFFCE, `PCX_RESP_OKAY);
    // skipping 0, 1 and 4 moves the bus and drops the serial port
    wr(`PCX_OFS_OUTMODE, 32'hFFFFFF, `PCX_RESP_OKAY);
    wr(`PCX_OFS_SKIP, 32'h000013, `PCX_RESP_OKAY);
    settle();
    chk(32'(per_out.uart_rx), 32'h1);
    rd(`PCX_OFS_ASSIGN, 32'h00000C, `PCX_RESP_OKAY);
    chk(32'(pad.oe[4:0]), 32'h17);
    chk(32'({per_out.sda_in, per_out.scl_in}), 32'h1);
    // crystal pins analog and skipped: bus back at 0 and 1
    wr(`PCX_OFS_INMODE, 32'hFFFFF3, `PCX_RESP_OKAY);
    wr(`PCX_OFS_SKIP, 32'h00000C, `PCX_RESP_OKAY);
    settle();
    rd(`PCX_OFS_ASSIGN, 32'h000033, `PCX_RESP_OKAY);
    chk(32'(pad.oe[3:2]), 32'h0);
    chk(32'(per_out.uart_rx), 32'h1);
    rd(`PCX_OFS_PADREAD, 32'hFFFFE2, `PCX_RESP_OKAY);
    $display("test crossbar done");
    end_of_test();
  end
endmodule
